// ---- pae_pkg.sv ----
// Notes on behaviour
// - Mode zero never raises the slot alarm.
// - Mode 1 alarms while measured value is above the alarm value.
// - Mode 2 alarms while measured value is below the alarm value.
// - Mode 3 alarms while signed deviation is above the alarm value.
// - Mode 4 alarms while signed deviation is below the alarm value.
// - Mode 5 alarms while deviation magnitude is above the alarm value.
// - Mode 6 alarms while deviation magnitude is below the alarm value.
// - Modes 7 to 11 repeat modes 1 to 5 with wait at control start.
// - Wait holds alarm off until the condition first clears; later entries alarm.
// - Modes 12 to 14 are deviation modes re-armed at start and setpoint change.
// - Cascade slave channel does not re-arm wait on setpoint change.
// - Nonzero change ratio limiter stops re-arm on setpoint change.
// - Each slot status is its own readable bit of the event word.
// - Slot one to four status sit in event bits four to seven.
// - Alarm only after condition persists more samples than the delay count.
package pae_pkg;
  localparam int DATA_W = 16;
  localparam int MODE_W = 4;
  localparam int SLOTS = 4;
  localparam int ADDR_W = 4;
  typedef enum logic [3:0] {
    PAE_OFF = 4'h0, PAE_UP_PV = 4'h1, PAE_LO_PV = 4'h2, PAE_UP_DEV = 4'h3,
    PAE_LO_DEV = 4'h4, PAE_OUT_BAND = 4'h5, PAE_IN_BAND = 4'h6, PAE_UP_PV_W = 4'h7,
    PAE_LO_PV_W = 4'h8, PAE_UP_DEV_W = 4'h9, PAE_LO_DEV_W = 4'ha, PAE_OUT_BAND_W = 4'hb,
    PAE_UP_DEV_RW = 4'hc, PAE_LO_DEV_RW = 4'hd, PAE_OUT_BAND_RW = 4'he
  } pae_mode_e;
  // register word addresses
  localparam logic [3:0] PAE_A_CTRL = 4'h0;
  localparam logic [3:0] PAE_A_SETPOINT = 4'h1;
  localparam logic [3:0] PAE_A_RATIO = 4'h2;
  localparam logic [3:0] PAE_A_DELAY = 4'h3;
  localparam logic [3:0] PAE_A_MODE = 4'h4;
  localparam logic [3:0] PAE_A_AVAL0 = 4'h5;
  localparam logic [3:0] PAE_A_AVAL1 = 4'h6;
  localparam logic [3:0] PAE_A_AVAL2 = 4'h7;
  localparam logic [3:0] PAE_A_AVAL3 = 4'h8;
  localparam logic [3:0] PAE_A_EVENT = 4'h9;
  localparam logic [3:0] PAE_A_IRQ_STATUS = 4'ha;
  localparam logic [3:0] PAE_A_IRQ_MASK = 4'hb;
  localparam logic [3:0] PAE_A_MEAS = 4'hc;
  // field positions and reset values
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_CASC_BIT = 1;
  localparam int EVT_ALARM_LSB = 4;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_MAX = 16'hffff;
endpackage : pae_pkg

// ---- pae_slot_if.sv ----
`timescale 1ns/100ps
// per-slot settings in, alarm state out
interface pae_slot_if;
  logic smp;
  logic signed [pae_pkg::DATA_W-1:0] pv;
  logic signed [pae_pkg::DATA_W-1:0] sv;
  pae_pkg::pae_mode_e mode;
  logic signed [pae_pkg::DATA_W-1:0] aval;
  logic [pae_pkg::DATA_W-1:0] delay;
  logic rearm_start;
  logic rearm_sv;
  logic alarm;
  logic rise;
  modport ctrl (output smp, pv, sv, mode, aval, delay, rearm_start, rearm_sv, input alarm, rise);
  modport slot (input smp, pv, sv, mode, aval, delay, rearm_start, rearm_sv, output alarm, rise);
endinterface : pae_slot_if

// ---- pae_slot.sv ----
`timescale 1ns/100ps
module pae_slot (
  input wire logic clk,
  input wire logic reset_n,
  pae_slot_if.slot sif
);
  typedef struct packed {
    logic armed;
    logic [pae_pkg::DATA_W-1:0] cnt;
    logic alarm;
    logic rise;
  } pae_slot_s;

  pae_slot_s s_r;
  pae_slot_s s_nxt;

  // comparison, wait and delay for one slot
  always_comb begin
    logic signed [pae_pkg::DATA_W:0] dev;
    logic signed [pae_pkg::DATA_W:0] adev;
    logic signed [pae_pkg::DATA_W:0] aext;
    logic cond;
    logic wait_mode;
    logic rewait_mode;
    logic [pae_pkg::DATA_W-1:0] cnt_n;
    dev = {sif.pv[pae_pkg::DATA_W-1], sif.pv} - {sif.sv[pae_pkg::DATA_W-1], sif.sv};
    adev = dev[pae_pkg::DATA_W] ? -dev : dev; // 17 bits, no overflow
    aext = {sif.aval[pae_pkg::DATA_W-1], sif.aval};
    cond = 1'b0;
    wait_mode = 1'b0;
    rewait_mode = 1'b0;
    case (sif.mode)
      pae_pkg::PAE_UP_PV: cond = sif.pv > sif.aval;
      pae_pkg::PAE_LO_PV: cond = sif.pv < sif.aval;
      pae_pkg::PAE_UP_DEV: cond = dev > aext;
      pae_pkg::PAE_LO_DEV: cond = dev < aext;
      pae_pkg::PAE_OUT_BAND: cond = adev > aext;
      pae_pkg::PAE_IN_BAND: cond = adev < aext;
      pae_pkg::PAE_UP_PV_W: begin
        cond = sif.pv > sif.aval;
        wait_mode = 1'b1;
      end
      pae_pkg::PAE_LO_PV_W: begin
        cond = sif.pv < sif.aval;
        wait_mode = 1'b1;
      end
      pae_pkg::PAE_UP_DEV_W: begin
        cond = dev > aext;
        wait_mode = 1'b1;
      end
      pae_pkg::PAE_LO_DEV_W: begin
        cond = dev < aext;
        wait_mode = 1'b1;
      end
      pae_pkg::PAE_OUT_BAND_W: begin
        cond = adev > aext;
        wait_mode = 1'b1;
      end
      pae_pkg::PAE_UP_DEV_RW: begin
        cond = dev > aext;
        wait_mode = 1'b1;
        rewait_mode = 1'b1;
      end
      pae_pkg::PAE_LO_DEV_RW: begin
        cond = dev < aext;
        wait_mode = 1'b1;
        rewait_mode = 1'b1;
      end
      pae_pkg::PAE_OUT_BAND_RW: begin
        cond = adev > aext;
        wait_mode = 1'b1;
        rewait_mode = 1'b1;
      end
      default: cond = 1'b0; // off and unused codes never alarm
    endcase
    cnt_n = cond ? ((s_r.cnt == pae_pkg::CNT_MAX) ? s_r.cnt : s_r.cnt + pae_pkg::CNT_ONE) : pae_pkg::RST_WORD;
    s_nxt = s_r;
    s_nxt.rise = 1'b0;
    if (sif.smp) begin
      s_nxt.cnt = cnt_n;
      if (!cond) begin
        s_nxt.armed = 1'b0;
      end
      s_nxt.alarm = cond && !s_r.armed && (cnt_n > sif.delay);
      s_nxt.rise = s_nxt.alarm && !s_r.alarm;
    end
    // re-arm wins over a clear in the same cycle
    if ((sif.rearm_start && wait_mode) || (sif.rearm_sv && rewait_mode)) begin
      s_nxt.armed = 1'b1;
    end
    if (sif.mode == pae_pkg::PAE_OFF) begin
      s_nxt.alarm = 1'b0;
      s_nxt.rise = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sif.alarm = s_r.alarm;
  assign sif.rise = s_r.rise;

  chk_delay_met: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(s_r.alarm) |-> (s_r.cnt > $past(sif.delay))) else $error("alarm rose before delay count");
  chk_sample_only: assert property (@(posedge clk) disable iff (!reset_n)
    (!sif.smp && sif.mode != pae_pkg::PAE_OFF) |=> $stable(s_r.alarm)) else $error("alarm moved off sample");
endmodule : pae_slot

// ---- pae_irq.sv ----
`timescale 1ns/100ps
module pae_irq #(
  parameter int N = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [N-1:0] ev,
  input wire logic clr_we,
  input wire logic [N-1:0] clr_data,
  input wire logic mask_we,
  input wire logic [N-1:0] mask_data,
  output logic [N-1:0] status,
  output logic [N-1:0] mask,
  output logic irq
);
  typedef struct packed {
    logic [N-1:0] status;
    logic [N-1:0] mask;
    logic irq;
  } pae_irq_s;

  pae_irq_s s_r;
  pae_irq_s s_nxt;

  // sticky bits, write one to clear; a new event beats the clear
  always_comb begin
    s_nxt = s_r;
    s_nxt.status = (s_r.status & ~(clr_we ? clr_data : '0)) | ev;
    if (mask_we) begin
      s_nxt.mask = mask_data;
    end
    s_nxt.irq = |(s_nxt.status & s_nxt.mask);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign status = s_r.status;
  assign mask = s_r.mask;
  assign irq = s_r.irq;
endmodule : pae_irq

// ---- pae_top.sv ----
`timescale 1ns/100ps
module pae_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sample_valid,
  input wire logic [pae_pkg::DATA_W-1:0] measured_value,
  input wire logic [pae_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pae_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pae_pkg::DATA_W-1:0] reg_rdata,
  output logic irq
);
  typedef struct packed {
    logic run;
    logic casc;
    logic [pae_pkg::DATA_W-1:0] sv;
    logic [pae_pkg::DATA_W-1:0] ratio;
    logic [pae_pkg::DATA_W-1:0] delay;
    logic [pae_pkg::SLOTS*pae_pkg::MODE_W-1:0] mode;
    logic [pae_pkg::SLOTS-1:0][pae_pkg::DATA_W-1:0] aval;
    logic smp;
    logic [pae_pkg::DATA_W-1:0] pv_smp;
    logic [pae_pkg::DATA_W-1:0] sv_smp;
    logic run_prev;
    logic rearm_start;
    logic rearm_sv;
    logic [pae_pkg::DATA_W-1:0] rdata;
  } pae_top_s;

  pae_top_s s_r;
  pae_top_s s_nxt;

  logic [pae_pkg::SLOTS-1:0] alarm_w;
  logic [pae_pkg::SLOTS-1:0] rise_w;
  logic [pae_pkg::SLOTS-1:0] irq_status_w;
  logic [pae_pkg::SLOTS-1:0] irq_mask_w;
  logic irq_clr_we;
  logic irq_mask_we;

  pae_slot_if sif [pae_pkg::SLOTS] ();

  // register writes, sample capture and re-arm pulses
  always_comb begin
    s_nxt = s_r;
    s_nxt.smp = sample_valid;
    if (sample_valid) begin
      s_nxt.pv_smp = measured_value;
      s_nxt.sv_smp = s_r.sv; // setpoint frozen with the sample
    end
    s_nxt.run_prev = s_r.run;
    s_nxt.rearm_start = s_r.run && !s_r.run_prev; // control start edge
    s_nxt.rearm_sv = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        pae_pkg::PAE_A_CTRL: begin
          s_nxt.run = reg_wdata[pae_pkg::CTRL_RUN_BIT];
          s_nxt.casc = reg_wdata[pae_pkg::CTRL_CASC_BIT];
        end
        pae_pkg::PAE_A_SETPOINT: begin
          s_nxt.sv = reg_wdata;
          // rewriting the same value is no change, so no re-arm
          s_nxt.rearm_sv = (reg_wdata != s_r.sv) && !s_r.casc
            && (s_r.ratio == pae_pkg::RST_WORD);
        end
        pae_pkg::PAE_A_RATIO: s_nxt.ratio = reg_wdata;
        pae_pkg::PAE_A_DELAY: s_nxt.delay = reg_wdata;
        pae_pkg::PAE_A_MODE: s_nxt.mode = reg_wdata;
        pae_pkg::PAE_A_AVAL0: s_nxt.aval[0] = reg_wdata;
        pae_pkg::PAE_A_AVAL1: s_nxt.aval[1] = reg_wdata;
        pae_pkg::PAE_A_AVAL2: s_nxt.aval[2] = reg_wdata;
        pae_pkg::PAE_A_AVAL3: s_nxt.aval[3] = reg_wdata;
        default: s_nxt.run = s_r.run; // status words are not written here
      endcase
    end
    // read data stand only in the cycle after the strobe
    s_nxt.rdata = pae_pkg::RST_WORD;
    if (reg_rd) begin
      case (reg_addr)
        pae_pkg::PAE_A_CTRL: begin
          s_nxt.rdata[pae_pkg::CTRL_RUN_BIT] = s_r.run;
          s_nxt.rdata[pae_pkg::CTRL_CASC_BIT] = s_r.casc;
        end
        pae_pkg::PAE_A_SETPOINT: s_nxt.rdata = s_r.sv;
        pae_pkg::PAE_A_RATIO: s_nxt.rdata = s_r.ratio;
        pae_pkg::PAE_A_DELAY: s_nxt.rdata = s_r.delay;
        pae_pkg::PAE_A_MODE: s_nxt.rdata = s_r.mode;
        pae_pkg::PAE_A_AVAL0: s_nxt.rdata = s_r.aval[0];
        pae_pkg::PAE_A_AVAL1: s_nxt.rdata = s_r.aval[1];
        pae_pkg::PAE_A_AVAL2: s_nxt.rdata = s_r.aval[2];
        pae_pkg::PAE_A_AVAL3: s_nxt.rdata = s_r.aval[3];
        pae_pkg::PAE_A_EVENT: begin
          s_nxt.rdata[pae_pkg::EVT_ALARM_LSB +: pae_pkg::SLOTS] = alarm_w;
        end
        pae_pkg::PAE_A_IRQ_STATUS: s_nxt.rdata[pae_pkg::SLOTS-1:0] = irq_status_w;
        pae_pkg::PAE_A_IRQ_MASK: s_nxt.rdata[pae_pkg::SLOTS-1:0] = irq_mask_w;
        pae_pkg::PAE_A_MEAS: s_nxt.rdata = s_r.pv_smp;
        default: s_nxt.rdata = pae_pkg::RST_WORD; // unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;

  // fan settings out to the four slots
  for (genvar i = 0; i < pae_pkg::SLOTS; i++) begin : g_slot
    assign sif[i].smp = s_r.smp;
    assign sif[i].pv = s_r.pv_smp;
    assign sif[i].sv = s_r.sv_smp;
    assign sif[i].mode = pae_pkg::pae_mode_e'(s_r.mode[i*pae_pkg::MODE_W +: pae_pkg::MODE_W]);
    assign sif[i].aval = s_r.aval[i];
    assign sif[i].delay = s_r.delay;
    assign sif[i].rearm_start = s_r.rearm_start;
    assign sif[i].rearm_sv = s_r.rearm_sv;
    assign alarm_w[i] = sif[i].alarm;
    assign rise_w[i] = sif[i].rise;

    pae_slot u_slot (
      .clk(clk),
      .reset_n(reset_n),
      .sif(sif[i])
    );
  end

  // interrupt status is set by each alarm rising edge
  assign irq_clr_we = reg_wr && (reg_addr == pae_pkg::PAE_A_IRQ_STATUS);
  assign irq_mask_we = reg_wr && (reg_addr == pae_pkg::PAE_A_IRQ_MASK);

  pae_irq #(
    .N(pae_pkg::SLOTS)
  ) u_irq (
    .clk(clk),
    .reset_n(reset_n),
    .ev(rise_w),
    .clr_we(irq_clr_we),
    .clr_data(reg_wdata[pae_pkg::SLOTS-1:0]),
    .mask_we(irq_mask_we),
    .mask_data(reg_wdata[pae_pkg::SLOTS-1:0]),
    .status(irq_status_w),
    .mask(irq_mask_w),
    .irq(irq)
  );

  // helper deviation of the captured sample, read only by checks
  logic signed [pae_pkg::DATA_W:0] dev_h;
  logic signed [pae_pkg::DATA_W:0] adev_h;
  assign dev_h = {s_r.pv_smp[pae_pkg::DATA_W-1], s_r.pv_smp} - {s_r.sv_smp[pae_pkg::DATA_W-1], s_r.sv_smp};
  assign adev_h = dev_h[pae_pkg::DATA_W] ? -dev_h : dev_h;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // per-slot comparison checks, one cycle ahead of the alarm flop
  for (genvar i = 0; i < pae_pkg::SLOTS; i++) begin : g_chk
    logic signed [pae_pkg::DATA_W:0] aext_h;
    assign aext_h = {s_r.aval[i][pae_pkg::DATA_W-1], s_r.aval[i]};

    chk_mode_off: assert property (
      sif[i].mode == pae_pkg::PAE_OFF |=> !sif[i].alarm) else $error("alarm while slot off");
    chk_upper_abs: assert property (
      s_r.smp && sif[i].mode == pae_pkg::PAE_UP_PV && $signed(s_r.pv_smp) > $signed(s_r.aval[i])
      && s_r.delay == pae_pkg::RST_WORD |=> sif[i].alarm) else $error("upper absolute alarm missing");
    chk_lower_abs: assert property (
      s_r.smp && sif[i].mode == pae_pkg::PAE_LO_PV && !($signed(s_r.pv_smp) < $signed(s_r.aval[i]))
      |=> !sif[i].alarm) else $error("lower absolute alarm false");
    chk_upper_dev: assert property (
      s_r.smp && sif[i].mode == pae_pkg::PAE_UP_DEV && dev_h > aext_h
      && s_r.delay == pae_pkg::RST_WORD |=> sif[i].alarm) else $error("upper deviation alarm missing");
    chk_lower_dev: assert property (
      s_r.smp && sif[i].mode == pae_pkg::PAE_LO_DEV && !(dev_h < aext_h)
      |=> !sif[i].alarm) else $error("lower deviation alarm false");
    chk_out_band: assert property (
      s_r.smp && sif[i].mode == pae_pkg::PAE_OUT_BAND && adev_h > aext_h
      && s_r.delay == pae_pkg::RST_WORD |=> sif[i].alarm) else $error("band alarm missing");
    chk_in_band: assert property (
      s_r.smp && sif[i].mode == pae_pkg::PAE_IN_BAND && !(adev_h < aext_h)
      |=> !sif[i].alarm) else $error("range alarm false");
    chk_wait_hold: assert property (
      (s_r.rearm_start && sif[i].mode == pae_pkg::PAE_UP_PV_W)
      ##1 (sif[i].mode == pae_pkg::PAE_UP_PV_W && (!s_r.smp || $signed(s_r.pv_smp) > $signed(s_r.aval[i])))[*8]
      |-> !sif[i].alarm) else $error("wait let start condition alarm");
    chk_wait_free: assert property (
      s_r.smp && sif[i].mode == pae_pkg::PAE_UP_PV_W && !($signed(s_r.pv_smp) > $signed(s_r.aval[i]))
      ##1 (!s_r.rearm_start && !s_r.smp)
      ##1 (s_r.smp && sif[i].mode == pae_pkg::PAE_UP_PV_W && !s_r.rearm_start
      && $signed(s_r.pv_smp) > $signed(s_r.aval[i]) && s_r.delay == pae_pkg::RST_WORD)
      |=> sif[i].alarm) else $error("alarm missing after wait cleared");
    chk_rewait_hold: assert property (
      (s_r.rearm_sv && sif[i].mode == pae_pkg::PAE_UP_DEV_RW)
      ##1 (sif[i].mode == pae_pkg::PAE_UP_DEV_RW && (!s_r.smp || dev_h > aext_h))[*4]
      |-> !sif[i].alarm) else $error("re-wait let setpoint step alarm");
  end

  chk_rearm_sv: assert property (
    reg_wr && reg_addr == pae_pkg::PAE_A_SETPOINT && reg_wdata != s_r.sv && !s_r.casc
    && s_r.ratio == pae_pkg::RST_WORD |=> s_r.rearm_sv) else $error("setpoint change did not re-arm");
  chk_cascade_skip: assert property (
    s_r.casc && !(reg_wr && reg_addr == pae_pkg::PAE_A_CTRL) |=> !s_r.rearm_sv)
    else $error("cascade slave re-armed");
  chk_ratio_skip: assert property (
    s_r.ratio != pae_pkg::RST_WORD && !(reg_wr && reg_addr == pae_pkg::PAE_A_RATIO) |=> !s_r.rearm_sv)
    else $error("ratio limiter re-armed");
  chk_event_read: assert property (
    reg_rd && reg_addr == pae_pkg::PAE_A_EVENT
    |=> reg_rdata[pae_pkg::EVT_ALARM_LSB +: pae_pkg::SLOTS] == $past(alarm_w)
    && reg_rdata[pae_pkg::EVT_ALARM_LSB-1:0] == '0) else $error("event word wrong");
  chk_irq_level: assert property (
    irq == |(irq_status_w & irq_mask_w)) else $error("irq not status and mask");

  cov_alarm_up: cover property (s_r.smp ##1 $rose(alarm_w[0]));
  cov_wait_then_alarm: cover property (s_r.rearm_start ##[1:200] $rose(alarm_w[1]));
  cov_rearm_sv: cover property (s_r.rearm_sv ##[1:50] s_r.smp);
  cov_irq: cover property ($rose(irq));
endmodule : pae_top

// ---- tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic sample_valid = 1'b0;
  logic [15:0] measured_value = 16'h0000;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic irq;
  int n_mismatch = 0;
  int num_checks = 0;
  // sample values straddle every threshold used below
  int pvs[8] = '{-200, 50, 99, 100, 101, 130, 131, 250};
  int avs[4] = '{-50, 0, 30, 150};

  // 50 mhz clock
  always #10 clk = ~clk;

  pae_top uut (
    .clk(clk),
    .reset_n(reset_n),
    .sample_valid(sample_valid),
    .measured_value(measured_value),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .irq(irq)
  );

  // single compare point, counts every comparison
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data only stands in the cycle after the strobe
  task automatic rchk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, e);
  endtask : rchk

  // alarm flop moves one edge after the capture edge
  task automatic smp(input int pv);
    @(posedge clk);
    sample_valid <= 1'b1;
    measured_value <= 16'(pv);
    @(posedge clk);
    sample_valid <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : smp

  task automatic set_av(input int a0, input int a1, input int a2, input int a3);
    wr(pae_pkg::PAE_A_AVAL0, 16'(a0));
    wr(pae_pkg::PAE_A_AVAL1, 16'(a1));
    wr(pae_pkg::PAE_A_AVAL2, 16'(a2));
    wr(pae_pkg::PAE_A_AVAL3, 16'(a3));
  endtask : set_av

  // reference comparison, wait modes fold onto their base comparison
  function automatic logic ex(input int m, input int pv, input int sv, input int av);
    int d;
    int a;
    d = pv - sv;
    a = (d < 0) ? -d : d;
    case (m)
      1, 7: return pv > av;
      2, 8: return pv < av;
      3, 9, 12: return d > av;
      4, 10, 13: return d < av;
      5, 11, 14: return a > av;
      6: return a < av;
      default: return 1'b0;
    endcase
  endfunction : ex

  function automatic logic [15:0] evw(input int m, input int pv);
    logic [3:0] b;
    for (int k = 0; k < 4; k++) b[k] = ex(m, pv, 100, avs[k]);
    return {8'h00, b, 4'h0};
  endfunction : evw

  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    for (int a = 0; a < 13; a++) rchk(4'(a), 16'h0000);
    rchk(4'hf, 16'h0000);
    wr(pae_pkg::PAE_A_CTRL, 16'hfffc);
    rchk(pae_pkg::PAE_A_CTRL, 16'h0000);
    wr(pae_pkg::PAE_A_EVENT, 16'hffff);
    rchk(pae_pkg::PAE_A_EVENT, 16'h0000);
    // every mode code with control stopped, so no waiting applies
    wr(pae_pkg::PAE_A_SETPOINT, 16'h0064);
    set_av(avs[0], avs[1], avs[2], avs[3]);
    for (int m = 0; m < 16; m++) begin
      wr(pae_pkg::PAE_A_MODE, {4{4'(m)}});
      for (int i = 0; i < 8; i++) begin
        smp(pvs[i]);
        rchk(pae_pkg::PAE_A_EVENT, evw(m, pvs[i]));
      end
    end
    rchk(pae_pkg::PAE_A_MEAS, 16'h00fa);
    // interrupt raise, mask and clear
    wr(pae_pkg::PAE_A_MODE, 16'h1111);
    smp(-200);
    wr(pae_pkg::PAE_A_IRQ_STATUS, 16'h000f);
    rchk(pae_pkg::PAE_A_IRQ_STATUS, 16'h0000);
    check({15'h0000, irq}, 16'h0000);
    wr(pae_pkg::PAE_A_IRQ_MASK, 16'h0001);
    smp(250);
    rchk(pae_pkg::PAE_A_IRQ_STATUS, 16'h000f);
    check({15'h0000, irq}, 16'h0001);
    wr(pae_pkg::PAE_A_IRQ_MASK, 16'h0000);
    rchk(pae_pkg::PAE_A_IRQ_MASK, 16'h0000);
    check({15'h0000, irq}, 16'h0000);
    wr(pae_pkg::PAE_A_IRQ_STATUS, 16'h0001);
    rchk(pae_pkg::PAE_A_IRQ_STATUS, 16'h000e);
    wr(pae_pkg::PAE_A_IRQ_MASK, 16'h0002);
    rchk(pae_pkg::PAE_A_IRQ_MASK, 16'h0002);
    check({15'h0000, irq}, 16'h0001);
    wr(pae_pkg::PAE_A_IRQ_STATUS, 16'h000f);
    rchk(pae_pkg::PAE_A_IRQ_STATUS, 16'h0000);
    check({15'h0000, irq}, 16'h0000);
    rchk(pae_pkg::PAE_A_EVENT, 16'h00f0);
    // wait at control start, slot 3 has no wait as reference
    wr(pae_pkg::PAE_A_MODE, 16'h1b97);
    set_av(150, 30, 30, 150);
    smp(250);
    rchk(pae_pkg::PAE_A_EVENT, 16'h00f0);
    wr(pae_pkg::PAE_A_CTRL, 16'h0001);
    repeat (3) @(posedge clk);
    smp(250);
    rchk(pae_pkg::PAE_A_EVENT, 16'h0080);
    smp(250);
    rchk(pae_pkg::PAE_A_EVENT, 16'h0080);
    smp(100);
    rchk(pae_pkg::PAE_A_EVENT, 16'h0000);
    smp(250);
    rchk(pae_pkg::PAE_A_EVENT, 16'h00f0);
    // re-wait on setpoint change, slot 3 only waits at start
    wr(pae_pkg::PAE_A_MODE, 16'h9edc);
    set_av(30, -30, 30, 30);
    smp(100);
    rchk(pae_pkg::PAE_A_EVENT, 16'h0000);
    wr(pae_pkg::PAE_A_SETPOINT, 16'h0000);
    smp(100);
    rchk(pae_pkg::PAE_A_EVENT, 16'h0080);
    smp(0);
    smp(100);
    rchk(pae_pkg::PAE_A_EVENT, 16'h00d0);
    // cascade slave and ratio limiter both skip the re-arm
    wr(pae_pkg::PAE_A_CTRL, 16'h0003);
    wr(pae_pkg::PAE_A_SETPOINT, 16'h0032);
    smp(100);
    rchk(pae_pkg::PAE_A_EVENT, 16'h00d0);
    wr(pae_pkg::PAE_A_CTRL, 16'h0001);
    wr(pae_pkg::PAE_A_RATIO, 16'h0005);
    wr(pae_pkg::PAE_A_SETPOINT, 16'h0000);
    smp(100);
    rchk(pae_pkg::PAE_A_EVENT, 16'h00d0);
    wr(pae_pkg::PAE_A_RATIO, 16'h0000);
    wr(pae_pkg::PAE_A_SETPOINT, 16'h0032);
    smp(100);
    rchk(pae_pkg::PAE_A_EVENT, 16'h0080);
    // delay count of two needs a third sample in a row
    wr(pae_pkg::PAE_A_MODE, 16'h1111);
    set_av(150, 150, 150, 150);
    wr(pae_pkg::PAE_A_DELAY, 16'h0002);
    smp(0);
    smp(250);
    rchk(pae_pkg::PAE_A_EVENT, 16'h0000);
    smp(250);
    rchk(pae_pkg::PAE_A_EVENT, 16'h0000);
    smp(250);
    rchk(pae_pkg::PAE_A_EVENT, 16'h00f0);
    smp(0);
    smp(250);
    rchk(pae_pkg::PAE_A_EVENT, 16'h0000);
    // mode off drops a standing alarm without a sample
    smp(250);
    smp(250);
    smp(250);
    rchk(pae_pkg::PAE_A_EVENT, 16'h00f0);
    wr(pae_pkg::PAE_A_MODE, 16'h0000);
    rchk(pae_pkg::PAE_A_EVENT, 16'h0000);
    end_of_test();
  end

  // hang guard, far above the length of the sequence
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end
endmodule : tb_top
